/* mar_top.sv */
// Purpose: splits misaligned data accesses into aligned bus cycles and
//          controls the bus during master and watchdog reset
// Assumes: 32-bit big-endian port, slave acknowledges with bus_ack
// Notes: instruction prefetch at an odd address raises addr_error
// Function
// - bytes aligned; words odd, longs non-multiple-four misaligned
// - data accepted at any address, no fault
// - odd instruction prefetch raises address error
// - noncachable misaligned access splits into aligned cycles
// - long at offset one: 23:16, 15:0, 31:24
// - misaligned word completes in two cycles
// - single reset kind reinitialises everything; addr_reg, data_reg, write_reg, bus_addr and bus_dout keep their values
// - reset input passes two-stage synchroniser
// - in reset data floats, controls negated
// - bus stays reset until first core cycle
// - reset aborts any cycle and reloads registers
// - boot select: 16-bit, 15 waits, no burst
// - watchdog resets when enabled and not serviced
// - watchdog reset floats or negates all signals; bus_addr keeps its last value
`timescale 1ns/10ps
`default_nettype none
module mar_top #(
	parameter logic [31:0] WDOG_TIMEOUT = mar_pkg::WDOG_TIMEOUT_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic master_reset_n_in,
	input wire logic boot_external,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic req_instr,
	input wire logic req_cachable,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic done,
	output logic addr_error,
	output logic [31:0] rdata,
	output logic misaligned,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_dout,
	output logic bus_dout_oe,
	input wire logic [31:0] bus_din,
	output logic [3:0] bus_lanes,
	output logic bus_start,
	output logic bus_rw_n,
	input wire logic bus_ack,
	output logic boot_chip_select,
	output logic [4:0] boot_port_bits,
	output logic [3:0] boot_wait_cycles,
	output logic boot_burst_read,
	output logic boot_burst_write,
	input wire logic wdog_enable,
	input wire logic wdog_key_valid,
	input wire logic [15:0] wdog_key,
	output logic in_reset
);
	typedef enum logic [1:0] {
		MAR_IDLE = 2'b00,
		MAR_CYCLE = 2'b01,
		MAR_HOLD = 2'b11
	} mar_state_t;

	mar_state_t state_reg;
	logic rst_sync;
	logic wdog_rst_reg;
	logic hold_reg;
	logic soft_rst;
	logic [31:0] wdog_cnt_reg;
	logic wdog_armed_reg;
	logic [31:0] addr_reg;
	logic [31:0] data_reg;
	logic [2:0] left_reg;
	logic write_reg;
	logic [1:0] piece_bytes;
	logic [3:0] piece_lanes;
	logic is_mis;
	logic [2:0] total_bytes;

	////////////////////////////////////////////////////////////////////////
	// reset path

	mar_reset_sync #(
		.STAGES(mar_pkg::SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.din_n(master_reset_n_in),
		.rst_sync(rst_sync)
	);

	// master and watchdog reset share one path: no other reset kind exists
	assign soft_rst = rst_sync | wdog_rst_reg;

	// the bus holds its reset state until the first core request
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_reg <= 1'b1;
		end else if (ce) begin
			if (soft_rst) begin
				hold_reg <= 1'b1;
			end else if (req_valid) begin
				hold_reg <= 1'b0;
			end
		end
	end

	assign in_reset = soft_rst | hold_reg;

	// the key pair must arrive in order; a missed window resets the chip
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wdog_cnt_reg <= '0;
			wdog_armed_reg <= 1'b0;
			wdog_rst_reg <= 1'b0;
		end else if (ce) begin
			if (rst_sync) begin
				wdog_cnt_reg <= '0;
				wdog_armed_reg <= 1'b0;
				wdog_rst_reg <= 1'b0;
			end else if (wdog_rst_reg) begin
				// one-cycle pulse, held on in_reset by hold_reg until the next request
				wdog_rst_reg <= 1'b0;
				wdog_cnt_reg <= '0;
			end else if (!wdog_enable) begin
				wdog_cnt_reg <= '0;
				wdog_armed_reg <= 1'b0;
			end else if (wdog_key_valid && wdog_key == mar_pkg::WDOG_KEY_A) begin
				wdog_armed_reg <= 1'b1;
			end else if (wdog_key_valid && wdog_armed_reg &&
				wdog_key == mar_pkg::WDOG_KEY_B) begin
				wdog_armed_reg <= 1'b0;
				wdog_cnt_reg <= '0;
			end else if (wdog_cnt_reg >= WDOG_TIMEOUT - 32'h1) begin
				wdog_rst_reg <= 1'b1;
			end else begin
				wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot chip select setup, fixed by wiring

	always_comb begin
		boot_port_bits = 5'(mar_pkg::BOOT_PORT_BITS);
		boot_wait_cycles = mar_pkg::BOOT_WAIT_CYCLES;
		boot_burst_read = mar_pkg::BOOT_BURST_READ;
		boot_burst_write = mar_pkg::BOOT_BURST_WRITE;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			boot_chip_select <= 1'b0;
		end else if (ce) begin
			boot_chip_select <= boot_external & ~in_reset &
				(state_reg == MAR_CYCLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alignment check and splitting

	always_comb begin
		unique case (req_size)
			mar_pkg::SZ_BYTE: begin
				total_bytes = 3'h1;
				is_mis = 1'b0;
			end
			mar_pkg::SZ_WORD: begin
				total_bytes = 3'h2;
				is_mis = req_addr[0];
			end
			default: begin
				total_bytes = 3'h4;
				is_mis = req_addr[1:0] != 2'h0;
			end
		endcase
	end

	assign misaligned = is_mis;

	// bytes this cycle: whole long if at least four left and word aligned, halfword if at least two left and even, else one byte
	always_comb begin
		piece_bytes = 2'h0;
		piece_lanes = mar_pkg::LANES_NONE;
		if (left_reg >= 3'h4 && addr_reg[1:0] == 2'h0) begin
			piece_bytes = 2'h0;
			piece_lanes = 4'hf;
		end else if (left_reg >= 3'h2 && addr_reg[0] == 1'b0) begin
			piece_bytes = 2'h2;
			piece_lanes = addr_reg[1] ? 4'h3 : 4'hc;
		end else begin
			piece_bytes = 2'h1;
			piece_lanes = 4'h8 >> addr_reg[1:0];
		end
	end

	assign req_ready = (state_reg == MAR_IDLE) & ~soft_rst;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= MAR_IDLE;
			addr_reg <= '0;
			data_reg <= '0;
			left_reg <= '0;
			write_reg <= 1'b0;
			done <= 1'b0;
			addr_error <= 1'b0;
			rdata <= '0;
		end else if (ce) begin
			done <= 1'b0;
			addr_error <= 1'b0;
			if (soft_rst) begin
				state_reg <= MAR_IDLE;
				left_reg <= '0;
				rdata <= '0;
			end else begin
				unique case (state_reg)
					MAR_IDLE: begin
						if (req_valid && req_instr && req_addr[0]) begin
							addr_error <= 1'b1;
							done <= 1'b1;
						end else if (req_valid) begin
							// cachable misses are whole lines elsewhere
							addr_reg <= req_addr;
							data_reg <= req_wdata;
							write_reg <= req_write;
							left_reg <= (is_mis && !req_cachable) ?
								total_bytes : 3'h4;
							if (!is_mis || req_cachable) begin
								addr_reg <= {req_addr[31:2], 2'h0};
							end
							state_reg <= MAR_CYCLE;
						end
					end
					MAR_CYCLE: begin
						state_reg <= MAR_HOLD;
					end
					MAR_HOLD: begin
						if (bus_ack) begin
							// shift the finished bytes in at the low end
							unique case (piece_bytes)
								2'h1: rdata <= {rdata[23:0],
									bus_din[(5'(3 - addr_reg[1:0]) * 8) +: 8]};
								2'h2: rdata <= {rdata[15:0],
									addr_reg[1] ? bus_din[15:0] : bus_din[31:16]};
								default: rdata <= bus_din;
							endcase
							addr_reg <= addr_reg + {30'h0, piece_bytes} +
								((piece_bytes == 2'h0) ? 32'h4 : 32'h0);
							if (piece_bytes == 2'h0 ||
								left_reg <= {1'b0, piece_bytes}) begin
								left_reg <= '0;
								done <= 1'b1;
								state_reg <= MAR_IDLE;
							end else begin
								left_reg <= left_reg - {1'b0, piece_bytes};
								state_reg <= MAR_CYCLE;
							end
						end
					end
					default: state_reg <= MAR_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus drivers: negated or floating while in reset, except bus_addr, which keeps its last value

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus_addr <= '0;
			bus_dout <= '0;
			bus_dout_oe <= 1'b0;
			bus_lanes <= mar_pkg::LANES_NONE;
			bus_start <= 1'b0;
			bus_rw_n <= 1'b1;
		end else if (ce) begin
			bus_start <= 1'b0;
			if (in_reset) begin
				bus_dout_oe <= 1'b0;
				bus_lanes <= mar_pkg::LANES_NONE;
				bus_rw_n <= 1'b1;
			end else if (state_reg == MAR_CYCLE) begin
				bus_addr <= addr_reg;
				bus_lanes <= piece_lanes;
				bus_start <= 1'b1;
				bus_rw_n <= ~write_reg;
				bus_dout_oe <= write_reg;
				// place operand bytes so the first byte sent is the most
				// significant remaining one
				bus_dout <= (data_reg << (6'(4 - left_reg) * 8))
					>> (6'(addr_reg[1:0]) * 8);
			end else if (state_reg == MAR_IDLE) begin
				bus_lanes <= mar_pkg::LANES_NONE;
				bus_dout_oe <= 1'b0;
				bus_rw_n <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* mar_pkg.sv */
// Purpose: shared constants for the misaligned access and reset block
// Assumes: 32-bit big-endian data bus, 100 MHz clock
// Notes: sizes and lane masks used by the splitter and the bus sequencer
package mar_pkg;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam int SYNC_STAGES = 2;
	localparam int BOOT_PORT_BITS = 16;
	localparam logic [3:0] BOOT_WAIT_CYCLES = 4'hf;
	localparam logic BOOT_BURST_READ = 1'b0;
	localparam logic BOOT_BURST_WRITE = 1'b0;
	localparam int RESET_MIN_CYCLES = 16;
	localparam logic [31:0] WDOG_TIMEOUT_DEFAULT = 32'h0000_1000;
	localparam logic [15:0] WDOG_KEY_A = 16'h0055;
	localparam logic [15:0] WDOG_KEY_B = 16'h00aa;
	localparam logic [3:0] LANES_NONE = 4'h0;
endpackage

/* mar_reset_sync.sv */
// Purpose: two-stage synchroniser for the active-low master reset pin
// Assumes: pin is sampled on the crystal clock
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module mar_reset_sync #(
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic din_n,
	output logic rst_sync
);
	logic [STAGES-1:0] sync_reg;

	initial begin
		if (STAGES < 2) $error("sync needs at least two stages");
	end

	// asserted low at the pin, seen as active high after STAGES edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_reg <= '1;
		end else begin
			sync_reg <= {sync_reg[STAGES-2:0], ~din_n};
		end
	end

	assign rst_sync = sync_reg[STAGES-1];
endmodule
`default_nettype wire

/* mar_chk.sv */
// Purpose: port checker for mar_top
// Assumes: one clock, reset async high
// Notes: bound to mar_top below
`timescale 1ns/10ps
`default_nettype none
module mar_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic master_reset_n_in,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_instr,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic done,
	input wire logic addr_error,
	input wire logic misaligned,
	input wire logic bus_dout_oe,
	input wire logic [3:0] bus_lanes,
	input wire logic bus_start,
	input wire logic bus_ack,
	input wire logic in_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic take;
	assign take = ce && req_valid && req_ready;
	////////////////////////////////////////////////////////////////////////
	flag_calc_a: assert property (
		misaligned == (req_size == 2'h1 && req_addr[0] ||
		req_size == 2'h2 && req_addr[1:0] != 2'h0)) else $error("bad flag");
	odd_fetch_a: assert property (take && req_instr && req_addr[0]
		|-> ##[1:4] (addr_error && done)) else $error("no fault");
	start_late_a: assert property (take && !(req_instr && req_addr[0])
		|-> ##[1:3] bus_start) else $error("no start");
	lane_shape_a: assert property (bus_start |-> bus_lanes inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) else $error("bad lanes");
	ack_done_a: assert property (done && !addr_error
		|-> $past(bus_ack)) else $error("done without ack");
	quiet_reset_a: assert property (in_reset && $past(in_reset)
		|-> !bus_dout_oe && !bus_start && !done) else $error("bus live");
	sync_lag_a: assert property ($fell(master_reset_n_in)
		|-> ##[1:3] in_reset) else $error("no reset");
	hold_req_a: assert property ($fell(in_reset)
		|-> req_valid || $past(req_valid)) else $error("early release");
	cover property (bus_start && bus_lanes == 4'h4);
	cover property (addr_error);
	cover property ($fell(in_reset));
endmodule
bind mar_top mar_chk i_mar_chk (.clk, .reset, .ce, .master_reset_n_in,
	.req_valid, .req_ready, .req_instr, .req_size, .req_addr, .done,
	.addr_error, .misaligned, .bus_dout_oe, .bus_lanes, .bus_start,
	.bus_ack, .in_reset);
`default_nettype wire

/* mar_mem_model.sv */
// Purpose: memory on the far side of the bus
// Assumes: four words, acknowledge after wait_cycles
// Notes: writes only the lanes flagged
`timescale 1ns/10ps
`default_nettype none
module mar_mem_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] wait_cycles,
	input wire logic bus_start,
	input wire logic bus_rw_n,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_dout,
	input wire logic [3:0] bus_lanes,
	output logic [31:0] bus_din,
	output logic bus_ack
);
	logic [31:0] mem [4];
	logic [3:0] cnt;
	logic busy;
	// inverse outside the ack so stale data never passes for a match
	assign bus_din = bus_ack ? mem[bus_addr[3:2]] : ~mem[bus_addr[3:2]];
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= 1'b0;
			if (bus_start) begin
				busy <= 1'b1;
				cnt <= wait_cycles;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				bus_ack <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		for (int b = 0; b < 4; b++) begin
			if (bus_ack && !bus_rw_n && bus_lanes[b]) begin
				mem[bus_addr[3:2]][8*b+:8] <= bus_dout[8*b+:8];
			end
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: scenarios for mar_top
// Assumes: mar_mem_model answers the bus
// Notes: watchdog timeout cut to 16 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
	logic clk, reset, ce, master_reset_n_in, boot_external, req_valid;
	logic req_ready, req_write, req_instr, req_cachable, done, addr_error;
	logic misaligned, bus_dout_oe, bus_start, bus_rw_n, bus_ack, in_reset;
	logic boot_chip_select, boot_burst_read, boot_burst_write, wdog_enable;
	logic wdog_key_valid, err;
	logic [1:0] req_size;
	logic [31:0] req_addr, req_wdata, rdata, bus_addr, bus_dout, bus_din, rd;
	logic [3:0] bus_lanes, boot_wait_cycles, wait_cycles;
	logic [3:0] ln [4];
	logic [4:0] boot_port_bits;
	logic [15:0] wdog_key;
	int num_errors, samples_checked, np, cycles, seen;
	mar_top #(.WDOG_TIMEOUT(32'h0000_0010)) i_mar_top (.clk, .reset, .ce,
		.master_reset_n_in, .boot_external, .req_valid, .req_ready,
		.req_write, .req_instr, .req_cachable, .req_size, .req_addr,
		.req_wdata, .done, .addr_error, .rdata, .misaligned, .bus_addr,
		.bus_dout, .bus_dout_oe, .bus_din, .bus_lanes, .bus_start, .bus_rw_n,
		.bus_ack, .boot_chip_select, .boot_port_bits, .boot_wait_cycles,
		.boot_burst_read, .boot_burst_write, .wdog_enable, .wdog_key_valid,
		.wdog_key, .in_reset);
	mar_mem_model i_mar_mem_model (.clk, .reset, .wait_cycles, .bus_start,
		.bus_rw_n, .bus_addr, .bus_dout, .bus_lanes, .bus_din, .bus_ack);
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one whole request; lanes of each piece land in ln
	task access(input logic w, i, input logic [1:0] s, input logic [31:0] a, d);
		np = 0;
		@(posedge clk);
		{req_write, req_instr, req_size, req_addr} <= {w, i, s, a};
		{req_wdata, req_valid} <= {d, 1'b1};
		for (int k = 0; k < 99 && req_ready !== 1'b1; k++) @(posedge clk) #1;
		@(posedge clk);
		req_valid <= 1'b0;
		// a refused fetch answers at the take edge itself, so look once now
		#1;
		for (int k = 0; k < 99 && done !== 1'b1; k++) begin
			@(posedge clk) #1;
			if (bus_start === 1'b1 && np < 4) ln[np++] = bus_lanes;
		end
		{err, rd} = {addr_error, rdata};
	endtask
	task t_split;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			{req_size, req_addr} <= {2'(k / 4), 32'(k % 4)};
			@(negedge clk);
			`CHK("flag", k / 4 == 1 && k % 2 || k / 4 == 2 && k % 4, misaligned)
		end
		access(1'b1, 1'b0, 2'h2, 32'h1, 32'h11223344);
		`CHK("pieces", 3, np)
		`CHK("order", 12'h438, {ln[0], ln[1], ln[2]})
		`CHK("fault", 1'b0, err)
		`CHK("mem", 32'h11223344, {i_mar_mem_model.mem[0][23:0], i_mar_mem_model.mem[1][31:24]})
		access(1'b0, 1'b0, 2'h2, 32'h1, 32'h0);
		`CHK("rdata", 32'h11223344, rd)
		wait_cycles <= 4'h3;
		access(1'b1, 1'b0, 2'h1, 32'h3, 32'h5566);
		`CHK("wpieces", 8'h21, {np[3:0], ln[0]})
		access(1'b0, 1'b0, 2'h1, 32'h3, 32'h0);
		`CHK("wdata", 16'h5566, rd[15:0])
		access(1'b0, 1'b1, 2'h1, 32'h5, 32'h0);
		`CHK("oddfetch", 2'h2, {err, np[0]})
		access(1'b0, 1'b1, 2'h1, 32'h4, 32'h0);
		`CHK("evenfetch", 1'b0, err)
		`CHK("boot", 11'h43c, {boot_port_bits, boot_wait_cycles,
			boot_burst_read, boot_burst_write})
	endtask
	task t_pin;
		@(posedge clk);
		{req_valid, req_size, req_addr} <= {1'b1, 2'h2, 32'h1};
		wait_cycles <= 4'h8;
		repeat (4) @(posedge clk);
		{master_reset_n_in, req_valid} <= 2'h0;
		seen = 0;
		// held past the sixteen-cycle minimum
		repeat (20) @(posedge clk) #1 seen += done;
		`CHK("abort", 0, seen)
		`CHK("quiet", 2'h2, {in_reset, bus_dout_oe})
		@(posedge clk);
		master_reset_n_in <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK("hold", 1'b1, in_reset)
		access(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
		`CHK("resume", 2'h0, {err, in_reset})
	endtask
	task t_wdog;
		seen = 0;
		@(posedge clk);
		wdog_enable <= 1'b1;
		repeat (60) @(posedge clk) #1 seen += in_reset;
		`CHK("bite", 1'b1, seen > 0)
		@(posedge clk);
		wdog_enable <= 1'b0;
		access(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
		@(posedge clk);
		{wdog_enable, seen} <= {1'b1, 32'h0};
		repeat (6) begin
			@(posedge clk);
			{wdog_key_valid, wdog_key} <= {1'b1, 16'h0055};
			@(posedge clk);
			wdog_key <= 16'h00aa;
			@(posedge clk);
			wdog_key_valid <= 1'b0;
			repeat (5) @(posedge clk) #1 seen += in_reset;
		end
		`CHK("fed", 0, seen)
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) if (++cycles == 20000) begin
		num_errors++;
		tally_and_finish;
	end
	initial begin
		{req_valid, req_write, req_instr, req_cachable, wdog_enable} = '0;
		{wdog_key_valid, wdog_key, req_size, req_addr, req_wdata} = '0;
		{reset, ce, master_reset_n_in, boot_external} = 4'hf;
		wait_cycles = 4'h0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_split;
		t_pin;
		t_wdog;
		tally_and_finish;
	end
endmodule
`default_nettype wire
